// >>> core/rstrk_pkg.sv
// Package for the reset source tracking block: register addresses, bit positions and timing.
// Assumes a 32-bit memory-mapped register port driven by the processor core.
package rstrk_pkg;
  localparam logic [31:0] RSTRK_STATUS_ADDR = 32'hFFFF0230;
  localparam logic [31:0] RSTRK_CLEAR_ADDR = 32'hFFFF0234;
  localparam logic [7:0] RSTRK_STATUS_RESET = 8'h01;
  localparam int RSTRK_POR_BIT = 0;
  localparam int RSTRK_WDT_BIT = 1;
  localparam int RSTRK_SW_BIT = 2;
  localparam int RSTRK_EXT_BIT = 3;
  localparam int RSTRK_NUM_SRC = 4;
  localparam logic [7:0] RSTRK_SRC_MASK = 8'h0F;
  localparam int RSTRK_LOW_VOLT_EN_BIT = 2;
  localparam int RSTRK_LOW_VOLT_FLAG_BIT = 6;
  localparam int RSTRK_CLK_NS = 10;
  localparam int RSTRK_PULSE_NS = 80;
  localparam int RSTRK_PULSE_CYC = (RSTRK_PULSE_NS + RSTRK_CLK_NS - 1) / RSTRK_CLK_NS;
  typedef enum logic [2:0] {
    RSTRK_RUN = 3'b001,
    RSTRK_HOLD = 3'b010,
    RSTRK_SWREQ = 3'b100
  } rstrk_state_t;
endpackage : rstrk_pkg

// >>> core/rstrk_sync.sv
// Two-flop synchroniser for a bank of asynchronous level inputs.
// Assumes the inputs are levels held for at least two clock periods.
`timescale 1ns/1ps
module rstrk_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk_in, // System clock.
  input wire logic rst_b_in, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] async_in, // Asynchronous levels.
  output logic [WIDTH-1:0] sync_out // Synchronised levels.
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;
endmodule : rstrk_sync

// >>> core/rstrk_top.sv
// Reset source tracking: records the last reset cause and issues the device-wide reset.
// Assumes the power-on reset drives rst_b_in; watchdog and pin requests arrive asynchronously.
// Summary of operation
// - Four distinct reset sources, each recorded separately.
// - Power-on reset sets status bit 0.
// - Watchdog timeout sets status bit 1.
// - External pin reset sets status bit 3.
// - Writing bit 2 starts recorded software reset.
// - Clear register ones clear matching status bits.
// - Status bits 7 to 4 read zero.
// - Status survives the reset it reports.
// - RAM valid after POR needs flag set when enabled.
`timescale 1ns/1ps
module rstrk_top
  import rstrk_pkg::*;
(
  input wire logic clk_in, // System clock, 100 MHz.
  input wire logic rst_b_in, // Power-on reset, synchronous, active low.
  input wire logic wdt_timeout_in, // Watchdog timeout request, asynchronous.
  input wire logic ext_rst_b_in, // External reset pin, active low, asynchronous.
  input wire logic [31:0] addr_in, // Register address.
  input wire logic wr_en_in, // Register write strobe.
  input wire logic rd_en_in, // Register read strobe.
  input wire logic [7:0] wdata_in, // Write data.
  input wire logic [7:0] high_voltage_config_zero_in, // Config byte, bit 2 enables flag.
  input wire logic [7:0] high_voltage_status_in, // Status byte, bit 6 is flag.
  output logic [7:0] rdata_out, // Read data.
  output logic sys_rst_b_out, // Device-wide reset, active low.
  output logic ram_valid_out // RAM contents trusted after power-on reset.
);
  logic [1:0] sync_raw;
  logic wdt_sync;
  logic ext_sync;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  logic ram_valid_ff;
  logic nxt_ram_valid;
  logic por_seen_ff;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  rstrk_state_t state_ff;
  rstrk_state_t nxt_state;

  // The pin is inverted before the shared bank, so a one always means reset wanted.
  rstrk_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .async_in({wdt_timeout_in, ~ext_rst_b_in}),
    .sync_out(sync_raw)
  );
  assign wdt_sync = sync_raw[1];
  assign ext_sync = sync_raw[0];

  wire sel_status = (addr_in == RSTRK_STATUS_ADDR);
  wire sel_clear = (addr_in == RSTRK_CLEAR_ADDR);
  wire wr_status = wr_en_in && sel_status;
  wire wr_clear = wr_en_in && sel_clear;
  wire sw_req = wr_status && wdata_in[RSTRK_SW_BIT];
  wire in_run = (state_ff == RSTRK_RUN);
  wire in_swreq = (state_ff == RSTRK_SWREQ);
  // Limitation: a watchdog or pin request that arrives outside RUN is never recorded; it can only stretch the pulse.
  wire wdt_evt = in_run && wdt_sync;
  wire ext_evt = in_run && ext_sync;
  wire cnt_done = (cnt_ff == 8'h00);
  wire low_voltage_ok = !high_voltage_config_zero_in[RSTRK_LOW_VOLT_EN_BIT] ||
                        high_voltage_status_in[RSTRK_LOW_VOLT_FLAG_BIT];

  // Sets are applied after clears so a cause that lands with a clear is kept.
  wire [7:0] set_bits = ({7'h00, wdt_evt} << RSTRK_WDT_BIT) |
                        ({7'h00, ext_evt} << RSTRK_EXT_BIT) |
                        ({7'h00, sw_req} << RSTRK_SW_BIT);
  wire [7:0] clr_bits = wr_clear ? wdata_in : 8'h00;
  // A new cause replaces the old ones so status shows only the causes set in that cycle.
  wire [7:0] base_bits = (|set_bits) ? 8'h00 : (status_ff & ~clr_bits);
  assign nxt_status = (base_bits | set_bits) & RSTRK_SRC_MASK;

  // Watchdog and pin requests beat a software request that lands in the same cycle.
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    unique case (state_ff)
      RSTRK_RUN: begin
        if (wdt_evt || ext_evt) begin
          nxt_state = RSTRK_HOLD;
          nxt_cnt = 8'(RSTRK_PULSE_CYC);
        end else if (sw_req) begin
          nxt_state = RSTRK_SWREQ;
        end
      end
      RSTRK_SWREQ: begin
        nxt_state = RSTRK_HOLD;
        nxt_cnt = 8'(RSTRK_PULSE_CYC);
      end
      // The counter reloads on every entry to HOLD, so each cause gets a full pulse.
      RSTRK_HOLD: begin
        // The pulse is stretched while any synchronised request is still asserted.
        if (cnt_done && !wdt_sync && !ext_sync) begin
          nxt_state = RSTRK_RUN;
        end else if (!cnt_done) begin
          nxt_cnt = cnt_ff - 8'h01;
        end
      end
    endcase
  end

  assign nxt_rdata = (rd_en_in && sel_status) ? (status_ff & RSTRK_SRC_MASK) : 8'h00;
  // RAM validity is sampled once, at the first edge after power-on reset is released.
  assign nxt_ram_valid = (!por_seen_ff) ? low_voltage_ok : ram_valid_ff;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      status_ff <= RSTRK_STATUS_RESET;
      state_ff <= RSTRK_HOLD;
      cnt_ff <= 8'(RSTRK_PULSE_CYC);
      rdata_ff <= 8'h00;
      por_seen_ff <= 1'b0;
      ram_valid_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      rdata_ff <= nxt_rdata;
      por_seen_ff <= 1'b1;
      ram_valid_ff <= nxt_ram_valid;
    end
  end

  assign rdata_out = rdata_ff;
  // The status register is outside this reset domain, so it keeps the cause.
  // The software request cycle keeps the device reset released so the write completes first.
  assign sys_rst_b_out = in_run || in_swreq;
  assign ram_valid_out = ram_valid_ff;

  // Checks on the recorded cause, the read path, the device reset and RAM validity.
  // All but the first are off during power-on reset, which forces every register.

  a_por_sets_bit0: assert property (@(posedge clk_in)
    $rose(rst_b_in) |-> status_ff == RSTRK_STATUS_RESET)
    else $error("Power-on did not record bit 0.");

  a_wdt_sets_bit1: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wdt_evt |=> status_ff[RSTRK_WDT_BIT] && !sys_rst_b_out)
    else $error("Watchdog cause not recorded.");

  a_ext_sets_bit3: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ext_evt |=> status_ff[RSTRK_EXT_BIT] && !sys_rst_b_out)
    else $error("Pin cause not recorded.");

  a_single_cause: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ((wdt_evt ^ ext_evt) && !sw_req) |=> $onehot(status_ff))
    else $error("More than one cause recorded.");

  a_sw_reset_seq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (sw_req && in_run && !wdt_evt && !ext_evt) |=> status_ff[RSTRK_SW_BIT] && sys_rst_b_out
      ##1 !sys_rst_b_out)
    else $error("Software reset sequence wrong.");

  a_sw_pulse_start: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    in_swreq |=> !sys_rst_b_out && cnt_ff == 8'(RSTRK_PULSE_CYC))
    else $error("Software request did not start a full pulse.");

  a_clear_clears: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_clear && set_bits == 8'h00) |=> (status_ff & $past(wdata_in)) == 8'h00)
    else $error("Clear did not clear status.");

  a_upper_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rdata_out[7:4] == 4'h0)
    else $error("Unused status bits read nonzero.");

  a_status_upper: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    status_ff[7:4] == 4'h0)
    else $error("Unused status bits were set.");

  a_read_status: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (rd_en_in && sel_status) |=> rdata_out == $past(status_ff))
    else $error("Status read returned wrong data.");

  a_other_read_zero: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !(rd_en_in && sel_status) |=> rdata_out == 8'h00)
    else $error("Read data not zero outside a status read.");

  a_status_kept: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (!sys_rst_b_out && !wr_clear && set_bits == 8'h00) |=> $stable(status_ff))
    else $error("Status lost during reset.");

  a_ram_valid_flag: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !por_seen_ff |=> ram_valid_out == $past(low_voltage_ok))
    else $error("RAM valid does not follow flag.");

  a_ram_valid_held: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    por_seen_ff |=> $stable(ram_valid_out))
    else $error("RAM valid changed after power-on.");

  a_reset_hold: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(sys_rst_b_out) |-> !sys_rst_b_out [*8])
    else $error("Device reset pulse too short.");

  a_source_holds: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (state_ff == RSTRK_HOLD && (wdt_sync || ext_sync)) |=> !sys_rst_b_out)
    else $error("Device reset released while a source is active.");

  a_run_stays: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (in_run && !wdt_sync && !ext_sync && !sw_req) |=> sys_rst_b_out)
    else $error("Device reset without a cause.");

  a_state_onehot: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $onehot(state_ff))
    else $error("Sequencer state is not one-hot.");

  a_zero_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_status && wdata_in == 8'h00 && in_run && !wdt_sync && !ext_sync) |=> sys_rst_b_out)
    else $error("Zero write caused a reset.");

  a_zero_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (wr_clear && wdata_in == 8'h00 && set_bits == 8'h00) |=> $stable(status_ff))
    else $error("Zero clear write changed status.");
endmodule : rstrk_top

// >>> sim/tb.sv
// Bench for the reset source tracking block: register reads and writes plus source pins.
// Assumes inputs change at falling edges and that read data shows one cycle after the strobe.
`timescale 1ns/1ps
module tb;
  import rstrk_pkg::*;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic wdt_timeout_in = 1'b0;
  logic ext_rst_b_in = 1'b1;
  logic [31:0] addr_in = 32'h0;
  logic wr_en_in = 1'b0;
  logic rd_en_in = 1'b0;
  logic [7:0] wdata_in = 8'h00;
  logic [7:0] hv_cfg = 8'h00;
  logic [7:0] hv_sta = 8'h00;
  logic [7:0] rdata_out;
  logic sys_rst_b_out;
  logic ram_valid_out;
  logic [7:0] rd;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clk_in = ~clk_in;
  rstrk_top i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wdt_timeout_in(wdt_timeout_in),
    .ext_rst_b_in(ext_rst_b_in), .addr_in(addr_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .wdata_in(wdata_in), .high_voltage_config_zero_in(hv_cfg),
    .high_voltage_status_in(hv_sta), .rdata_out(rdata_out), .sys_rst_b_out(sys_rst_b_out),
    .ram_valid_out(ram_valid_out));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr_en_in = w;
    rd_en_in = ~w;
    addr_in = a;
    wdata_in = d;
    @(negedge clk_in);
    wr_en_in = 1'b0;
    rd_en_in = 1'b0;
    rd = rdata_out;
  endtask : acc
  task automatic por(input logic [7:0] c, input logic [7:0] s);
    @(negedge clk_in);
    rst_b_in = 1'b0;
    hv_cfg = c;
    hv_sta = s;
    repeat (16) @(negedge clk_in);
    rst_b_in = 1'b1;
    repeat (12) @(negedge clk_in);
  endtask : por
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    for (int i = 0; i < 3; i++) begin
      por((i == 0) ? 8'h00 : 8'h04, (i == 2) ? 8'h40 : 8'h00);
      chk({7'h0, ram_valid_out}, {7'h0, i != 1});
    end
    $display("test power-on done");
    acc(0, RSTRK_STATUS_ADDR, 8'h00);
    chk(rd, RSTRK_STATUS_RESET);
    acc(0, RSTRK_CLEAR_ADDR, 8'h00);
    chk(rd, 8'h00);
    acc(0, RSTRK_CLEAR_ADDR + 32'h4, 8'h00);
    chk(rd, 8'h00);
    acc(1, RSTRK_CLEAR_ADDR, 8'h01);
    acc(1, RSTRK_STATUS_ADDR, 8'h00);
    acc(0, RSTRK_STATUS_ADDR, 8'h00);
    chk(rd, 8'h00);
    chk({7'h0, sys_rst_b_out}, 8'h01);
    $display("test registers done");
    acc(1, RSTRK_STATUS_ADDR, 8'hF4);
    chk({7'h0, sys_rst_b_out}, 8'h01);
    @(negedge clk_in);
    chk({7'h0, sys_rst_b_out}, 8'h00);
    repeat (12) @(negedge clk_in);
    chk({7'h0, sys_rst_b_out}, 8'h01);
    acc(0, RSTRK_STATUS_ADDR, 8'h00);
    chk(rd, 8'h04);
    acc(1, RSTRK_CLEAR_ADDR, 8'hFB);
    acc(0, RSTRK_STATUS_ADDR, 8'h00);
    chk(rd, 8'h04);
    acc(1, RSTRK_CLEAR_ADDR, 8'h04);
    acc(0, RSTRK_STATUS_ADDR, 8'h00);
    chk(rd, 8'h00);
    $display("test software reset done");
    for (int i = 0; i < 2; i++) begin
      @(negedge clk_in);
      if (i == 0) wdt_timeout_in = 1'b1;
      else ext_rst_b_in = 1'b0;
      repeat (5) @(negedge clk_in);
      chk({7'h0, sys_rst_b_out}, 8'h00);
      wdt_timeout_in = 1'b0;
      ext_rst_b_in = 1'b1;
      repeat (20) @(negedge clk_in);
      acc(0, RSTRK_STATUS_ADDR, 8'h00);
      chk(rd, (i == 0) ? 8'h02 : 8'h08);
    end
    $display("test sources done");
    print_verdict();
  end
endmodule : tb
